// ---- shared/memdec_pkg.sv ----
package memdec_pkg;

    // ===
    // Program space
    localparam logic [15:0] RESET_VECTOR     = 16'h0000;
    localparam logic [15:0] VECTOR_BASE      = 16'h0003;
    localparam int          VECTOR_SPACING   = 8;
    localparam int          VECTOR_COUNT     = 16;
    localparam int          APP_FLASH_BYTES  = 65536;
    localparam int          LDR_FLASH_BYTES  = 4096;
    localparam int          FLASH_PAGE_BYTES = 256;
    localparam int          CODE_LOCK_BIT    = 2;
    // Loader bank start in the unified flash address space; arbitrary
    localparam logic [16:0] LDR_FLASH_BASE   = 17'h10000;

    // ===
    // Data space
    localparam logic [7:0]  UPPER_BOUND      = 8'h7f;
    localparam logic [7:0]  BIT_AREA_BASE    = 8'h20;
    localparam logic [7:0]  SP_RESET         = 8'h07;
    localparam int          BANK_SEL_LOW_BIT = 3;
    localparam int          BANK_SEL_HIGH_BIT = 4;
    localparam int          AUX_RAM_BYTES    = 1024;
    localparam logic [15:0] AUX_RAM_TOP      = 16'h03ff;

    // ===
    // Flash controller commands
    typedef enum logic [1:0] {
        FL_IDLE    = 2'h0,
        FL_READ    = 2'h1,
        FL_PROGRAM = 2'h2,
        FL_ERASE   = 2'h3
    } flash_cmd_type;

    typedef enum logic [1:0] {
        FL_BANK_APP = 2'h0,
        FL_BANK_LDR = 2'h1,
        FL_BANK_CFG = 2'h2
    } flash_bank_type;

    // External fetch sequencer, Gray along the usual path
    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_ADDR = 2'b01,
        XF_READ = 2'b11,
        XF_DONE = 2'b10
    } xfetch_state_type;

    typedef struct packed {
        logic        req;
        logic [15:0] addr;
        logic        code_read;
        logic        from_external;
    } fetch_req_type;

    typedef struct packed {
        logic       req;
        logic       write;
        logic       direct;
        logic [7:0] addr;
        logic [7:0] wdata;
    } data_req_type;

    typedef struct packed {
        logic       push;
        logic       pop;
        logic       load;
        logic [7:0] load_value;
        logic [7:0] wdata;
    } stack_req_type;

endpackage : memdec_pkg

// ---- hw/stack_unit.sv ----
`timescale 1ns/1ps
module stack_unit (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire memdec_pkg::stack_req_type req,
    output logic                          ram_we,
    output logic                          ram_re,
    output logic [7:0]                    ram_addr,
    output logic [7:0]                    sp
);
    typedef struct packed {
        logic [7:0] sp;
    } state_type;

    state_type s_q;
    state_type s_d;

    // ===
    // Pointer update
    always_comb begin
        s_d = s_q;
        if (req.load) begin
            s_d.sp = req.load_value;
        end else if (req.push) begin
            s_d.sp = s_q.sp + 8'h01;
        end else if (req.pop) begin
            s_d.sp = s_q.sp - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q.sp <= memdec_pkg::SP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Push writes at the incremented pointer, pop reads before decrement
    assign ram_we   = req.push && !req.load;
    assign ram_re   = req.pop && !req.push && !req.load;
    assign ram_addr = req.push ? s_d.sp : s_q.sp;
    assign sp       = s_q.sp;
endmodule : stack_unit

// ---- hw/flash_ctrl.sv ----
`timescale 1ns/1ps
module flash_ctrl #(
    parameter int PAGE_BYTES = memdec_pkg::FLASH_PAGE_BYTES,
    parameter int DEPTH      = 1024
) (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire memdec_pkg::flash_cmd_type  cmd,
    input  wire logic [$clog2(DEPTH)-1:0]   addr,
    input  wire logic [7:0]                 wdata,
    output logic [7:0]                      rdata
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = $clog2(PAGE_BYTES);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [7:0]            rdata;
    } state_type;

    state_type s_q;
    state_type s_d;

    // ===
    // Page erase, byte program, byte read
    always_comb begin
        s_d = s_q;
        case (cmd)
            memdec_pkg::FL_READ: begin
                s_d.rdata = s_q.mem[addr];
            end
            memdec_pkg::FL_PROGRAM: begin
                // Flash only clears bits; erase restores ones
                s_d.mem[addr] = s_q.mem[addr] & wdata;
            end
            memdec_pkg::FL_ERASE: begin
                for (int i = 0; i < DEPTH; i++) begin
                    if (i[AW-1:PW] == addr[AW-1:PW]) begin
                        s_d.mem[i] = 8'hff;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q.rdata <= 8'h00;
            s_q.mem   <= s_d.mem;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
endmodule : flash_ctrl

// ---- hw/mem_space_decoder.sv ----
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module mem_space_decoder #(
    parameter int LDR_BYTES = memdec_pkg::LDR_FLASH_BYTES,
    parameter int AUX_BYTES = memdec_pkg::AUX_RAM_BYTES
) (
    input  wire logic                          CLK,
    input  wire logic                          SRST,
    input  wire logic                          POWER_ON,
    input  wire logic                          EXTERNAL_ACCESS_SELECT,
    input  wire logic                          BOOT_FROM_LOADER,
    input  wire logic [7:0]                    CONFIG_BYTE_ZERO,
    input  wire logic                          AUX_RAM_ENABLE,
    input  wire logic [7:0]                    PROGRAM_STATUS_WORD,
    input  wire memdec_pkg::fetch_req_type     FETCH,
    input  wire logic                          VECTOR_REQ,
    input  wire logic [3:0]                    VECTOR_NUM,
    input  wire memdec_pkg::data_req_type      DATA,
    input  wire logic                          REG_REQ,
    input  wire logic [2:0]                    REG_NUM,
    input  wire logic                          BIT_REQ,
    input  wire logic [7:0]                    BIT_ADDR,
    input  wire memdec_pkg::stack_req_type     STACK,
    input  wire logic                          CALL_REQ,
    input  wire logic [15:0]                   RETURN_ADDR,
    input  wire logic                          XMOVE_REQ,
    input  wire logic                          XMOVE_WRITE,
    input  wire logic                          XMOVE_WIDE,
    input  wire logic [15:0]                   XMOVE_ADDR,
    input  wire logic [7:0]                    XMOVE_WDATA,
    input  wire logic [7:0]                    PORT0_IN,
    input  wire logic [7:0]                    PORT0_GPIO,
    input  wire logic [7:0]                    PORT2_GPIO,
    output logic [16:0]                        FLASH_ADDR,
    output logic                               FLASH_READ,
    output logic [7:0]                         FETCH_DATA,
    output logic                               FETCH_DONE,
    output logic                               CODE_READ_BLOCKED,
    output logic [7:0]                         PORT0_OUT,
    output logic                               PORT0_OE,
    output logic [7:0]                         PORT2_OUT,
    output logic                               PROGRAM_STORE_STROBE_N,
    output logic                               DATA_RD_N,
    output logic                               DATA_WR_N,
    output logic                               SFR_SEL,
    output logic                               SFR_BIT_OK,
    output logic [7:0]                         RAM_ADDR,
    output logic                               RAM_WE,
    output logic [7:0]                         RAM_WDATA,
    output logic [7:0]                         RAM_RDATA,
    output logic                               BIT_VALUE,
    output logic [7:0]                         XMOVE_RDATA,
    output logic [7:0]                         STACK_POINTER,
    output logic [15:0]                        START_ADDR,
    output logic                               EXTERNAL_MODE
);
    localparam int XAW = $clog2(AUX_BYTES);

    typedef struct packed {
        logic                         pin_s1;
        logic                         pin_s2;
        logic                         ea_latched;
        logic                         ea_valid;
        memdec_pkg::xfetch_state_type xf;
        logic [16:0]                  flash_addr;
        logic                         flash_read;
        logic [7:0]                   fetch_data;
        logic                         fetch_done;
        logic                         blocked;
        logic [7:0]                   p0_out;
        logic                         p0_oe;
        logic [7:0]                   p2_out;
        logic                         program_store_strobe_n;
        logic                         rd_n;
        logic                         wr_n;
        logic                         sfr_sel;
        logic                         sfr_bit;
        logic [7:0]                   ram_addr;
        logic                         ram_we;
        logic [7:0]                   ram_wdata;
        logic [7:0]                   ram_rdata;
        logic                         bit_value;
        logic [7:0]                   x_rdata;
        logic [15:0]                  start_addr;
        logic                         call_hi;
        logic [7:0]                   ret_hi;
        logic [255:0][7:0]            ram;
        logic [AUX_BYTES-1:0][7:0]    aux;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic       stk_we;
    logic       stk_re;
    logic [7:0] stk_addr;
    logic [7:0] sp;
    memdec_pkg::stack_req_type stk_req;

    // ===
    // Stack: calls push low byte then high byte of the return address
    always_comb begin
        stk_req = STACK;
        if (CALL_REQ) begin
            stk_req.push  = 1'b1;
            stk_req.wdata = RETURN_ADDR[7:0];
        end else if (s_q.call_hi) begin
            stk_req.push  = 1'b1;
            stk_req.wdata = s_q.ret_hi;
        end
    end

    stack_unit u_stack (
        .clk      (CLK),
        .srst     (SRST),
        .req      (stk_req),
        .ram_we   (stk_we),
        .ram_re   (stk_re),
        .ram_addr (stk_addr),
        .sp       (sp)
    );

    // ===
    // Main decode
    always_comb begin
        logic [16:0] bank_size;
        logic        internal;
        logic [7:0]  a;
        logic [7:0]  bank_base;
        bank_size = '0;
        internal  = 1'b0;
        a         = '0;
        bank_base = '0;
        s_d = s_q;
        s_d.flash_read = 1'b0;
        s_d.fetch_done = 1'b0;
        s_d.blocked    = 1'b0;
        s_d.ram_we     = 1'b0;
        s_d.call_hi    = CALL_REQ;
        s_d.ret_hi     = RETURN_ADDR[15:8];
        s_d.rd_n       = 1'b1;
        s_d.wr_n       = 1'b1;

        // Pin crosses two flops; latch on every cycle that POWER_ON is high
        s_d.pin_s1 = EXTERNAL_ACCESS_SELECT;
        s_d.pin_s2 = s_q.pin_s1;
        if (POWER_ON) begin
            s_d.ea_latched = s_q.pin_s2;
            s_d.ea_valid   = 1'b1;
        end

        // Reset vector is 0000H of whichever bank is booted
        s_d.start_addr = memdec_pkg::RESET_VECTOR;

        // Program fetch
        bank_size = BOOT_FROM_LOADER ? 17'(LDR_BYTES)
                                     : 17'(memdec_pkg::APP_FLASH_BYTES);
        internal  = s_q.ea_latched && ({1'b0, FETCH.addr} < bank_size);
        case (s_q.xf)
            memdec_pkg::XF_IDLE: begin
                if (VECTOR_REQ) begin
                    // Vectors follow the booted bank
                    s_d.flash_addr = (BOOT_FROM_LOADER
                        ? memdec_pkg::LDR_FLASH_BASE : 17'h00000)
                        + 17'(memdec_pkg::VECTOR_BASE)
                        + 17'(VECTOR_NUM) * 17'(memdec_pkg::VECTOR_SPACING);
                    s_d.flash_read = 1'b1;
                end else if (FETCH.req) begin
                    if (FETCH.code_read && FETCH.from_external &&
                        !CONFIG_BYTE_ZERO[memdec_pkg::CODE_LOCK_BIT] &&
                        internal) begin
                        s_d.blocked    = 1'b1;
                        s_d.fetch_data = 8'hff;
                        s_d.fetch_done = 1'b1;
                    end else if (internal) begin
                        s_d.flash_addr = BOOT_FROM_LOADER
                            ? memdec_pkg::LDR_FLASH_BASE + 17'(FETCH.addr)
                            : {1'b0, FETCH.addr};
                        s_d.flash_read = 1'b1;
                    end else begin
                        s_d.p0_out = FETCH.addr[7:0];
                        s_d.p0_oe  = 1'b1;
                        s_d.p2_out = FETCH.addr[15:8];
                        s_d.xf     = memdec_pkg::XF_ADDR;
                    end
                end
            end
            memdec_pkg::XF_ADDR: begin
                s_d.p0_oe  = 1'b0;
                s_d.program_store_strobe_n = 1'b0;
                s_d.xf     = memdec_pkg::XF_READ;
            end
            memdec_pkg::XF_READ: begin
                s_d.fetch_data = PORT0_IN;
                s_d.program_store_strobe_n     = 1'b1;
                s_d.fetch_done = 1'b1;
                s_d.xf         = memdec_pkg::XF_DONE;
            end
            default: begin
                s_d.xf = memdec_pkg::XF_IDLE;
            end
        endcase
        if (s_q.flash_read) begin
            s_d.fetch_done = 1'b1;
        end

        // External move: aux RAM or external data bus
        if (XMOVE_REQ) begin
            if (AUX_RAM_ENABLE && XMOVE_ADDR <= memdec_pkg::AUX_RAM_TOP) begin
                if (XMOVE_WRITE) begin
                    s_d.aux[XMOVE_ADDR[XAW-1:0]] = XMOVE_WDATA;
                end else begin
                    s_d.x_rdata = s_q.aux[XMOVE_ADDR[XAW-1:0]];
                end
            end else begin
                s_d.p0_out = XMOVE_WRITE ? XMOVE_WDATA : XMOVE_ADDR[7:0];
                s_d.p0_oe  = XMOVE_WRITE;
                if (XMOVE_WIDE) begin
                    s_d.p2_out = XMOVE_ADDR[15:8];
                end
                s_d.rd_n = XMOVE_WRITE;
                s_d.wr_n = !XMOVE_WRITE;
                s_d.x_rdata = PORT0_IN;
            end
        end else if (s_d.xf == memdec_pkg::XF_IDLE) begin
            // Next state, so a fetch address is not overwritten by GPIO
            s_d.p0_out = PORT0_GPIO;
            s_d.p2_out = PORT2_GPIO;
            s_d.p0_oe  = 1'b1;
        end

        // Internal data RAM
        if (stk_we || stk_re) begin
            a = stk_addr;
            s_d.sfr_sel = 1'b0;
            if (stk_we) begin
                s_d.ram[a]  = stk_req.wdata;
                s_d.ram_we  = 1'b1;
            end
            s_d.ram_rdata = s_q.ram[a];
        end else if (REG_REQ) begin
            bank_base = {3'b000,
                PROGRAM_STATUS_WORD[memdec_pkg::BANK_SEL_HIGH_BIT],
                PROGRAM_STATUS_WORD[memdec_pkg::BANK_SEL_LOW_BIT],
                3'b000};
            a = bank_base | {5'b00000, REG_NUM};
            s_d.sfr_sel = 1'b0;
            if (DATA.write) begin
                s_d.ram[a] = DATA.wdata;
                s_d.ram_we = 1'b1;
            end
            s_d.ram_rdata = s_q.ram[a];
        end else if (BIT_REQ && !BIT_ADDR[7]) begin
            a = memdec_pkg::BIT_AREA_BASE + {4'h0, BIT_ADDR[6:3]};
            s_d.sfr_sel   = 1'b0;
            s_d.bit_value = s_q.ram[a][BIT_ADDR[2:0]];
        end else if (BIT_REQ) begin
            a = {BIT_ADDR[7:3], 3'b000};
            s_d.sfr_sel = 1'b1;
            s_d.sfr_bit = 1'b1;
        end else if (DATA.req) begin
            a = DATA.addr;
            // Low half is shared by both modes
            s_d.sfr_sel = DATA.direct && (a > memdec_pkg::UPPER_BOUND);
            s_d.sfr_bit = s_d.sfr_sel && (a[2:0] == 3'b000);
            if (!s_d.sfr_sel) begin
                if (DATA.write) begin
                    s_d.ram[a] = DATA.wdata;
                    s_d.ram_we = 1'b1;
                end
                s_d.ram_rdata = s_q.ram[a];
            end
        end
        s_d.ram_addr  = a;
        s_d.ram_wdata = stk_we ? stk_req.wdata : DATA.wdata;
    end

    // ===
    // Configuration flash store, command tied idle; flash contents are not reset
    flash_ctrl #(
        .PAGE_BYTES (memdec_pkg::FLASH_PAGE_BYTES),
        .DEPTH      (1024)
    ) u_cfg_flash (
        .clk   (CLK),
        .srst  (SRST),
        .cmd   (memdec_pkg::FL_IDLE),
        .addr  (10'h000),
        .wdata (8'hff),
        .rdata ()
    );

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_q            <= s_d;
            s_q.xf         <= memdec_pkg::XF_IDLE;
            s_q.flash_read <= 1'b0;
            s_q.fetch_done <= 1'b0;
            s_q.blocked    <= 1'b0;
            s_q.p0_oe      <= 1'b0;
            s_q.p0_out     <= 8'hff;
            s_q.p2_out     <= 8'hff;
            s_q.program_store_strobe_n     <= 1'b1;
            s_q.rd_n       <= 1'b1;
            s_q.wr_n       <= 1'b1;
            s_q.ram_we     <= 1'b0;
            s_q.call_hi    <= 1'b0;
            s_q.start_addr <= memdec_pkg::RESET_VECTOR;
        end else begin
            s_q <= s_d;
        end
    end

    assign FLASH_ADDR             = s_q.flash_addr;
    assign FLASH_READ             = s_q.flash_read;
    assign FETCH_DATA             = s_q.fetch_data;
    assign FETCH_DONE             = s_q.fetch_done;
    assign CODE_READ_BLOCKED      = s_q.blocked;
    assign PORT0_OUT              = s_q.p0_out;
    assign PORT0_OE               = s_q.p0_oe;
    assign PORT2_OUT              = s_q.p2_out;
    assign PROGRAM_STORE_STROBE_N = s_q.program_store_strobe_n;
    assign DATA_RD_N              = s_q.rd_n;
    assign DATA_WR_N              = s_q.wr_n;
    assign SFR_SEL                = s_q.sfr_sel;
    assign SFR_BIT_OK             = s_q.sfr_bit;
    assign RAM_ADDR               = s_q.ram_addr;
    assign RAM_WE                 = s_q.ram_we;
    assign RAM_WDATA              = s_q.ram_wdata;
    assign RAM_RDATA              = s_q.ram_rdata;
    assign BIT_VALUE              = s_q.bit_value;
    assign XMOVE_RDATA            = s_q.x_rdata;
    assign STACK_POINTER          = sp;
    assign START_ADDR             = s_q.start_addr;
    assign EXTERNAL_MODE          = !s_q.ea_latched;
endmodule : mem_space_decoder

// ---- verif/ext_prog_mem.sv ----
`timescale 1ns/1ps
// ===
// External program memory
module ext_prog_mem (
    input  wire logic       clk,
    input  wire logic       oe,
    input  wire logic [7:0] lo,
    input  wire logic [7:0] hi,
    input  wire logic       strobe_n,
    output logic      [7:0] rdata
);
    logic [15:0] addr_q;
    logic        tog_q = 1'b0;
    always_ff @(posedge clk) begin
        if (oe) addr_q <= {hi, lo};
        tog_q <= ~tog_q;
    end
    // Released bus flips each cycle so a stale byte never looks valid
    assign rdata = strobe_n ? {8{tog_q}} : addr_q[7:0] ^ addr_q[15:8] ^ 8'h5a;
endmodule : ext_prog_mem

// ---- verif/mem_space_decoder_assertions.sv ----
`timescale 1ns/1ps
module mem_space_decoder_assertions (
    input wire logic CLK, SRST, BOOT_FROM_LOADER, AUX_RAM_ENABLE, VECTOR_REQ,
    input wire logic REG_REQ, BIT_REQ, XMOVE_REQ, XMOVE_WRITE, XMOVE_WIDE,
    input wire logic FLASH_READ, FETCH_DONE, CODE_READ_BLOCKED, PORT0_OE,
    input wire logic PROGRAM_STORE_STROBE_N, DATA_RD_N, DATA_WR_N, SFR_SEL,
    input wire logic SFR_BIT_OK, RAM_WE, EXTERNAL_MODE,
    input wire logic [7:0] CONFIG_BYTE_ZERO, PORT0_OUT, PORT2_OUT,
    input wire logic [7:0] RAM_ADDR, STACK_POINTER,
    input wire logic [3:0] VECTOR_NUM,
    input wire logic [15:0] XMOVE_ADDR,
    input wire logic [16:0] FLASH_ADDR,
    input wire memdec_pkg::fetch_req_type FETCH,
    input wire memdec_pkg::data_req_type DATA,
    input wire memdec_pkg::stack_req_type STACK
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // ===
    // External fetch walk
    sequence addr_out_s;
        PORT0_OE && {PORT2_OUT, PORT0_OUT} == $past(FETCH.addr);
    endsequence
    sequence strobe_s;
        !PORT0_OE && !PROGRAM_STORE_STROBE_N;
    endsequence
    ext_fetch_a: assert property (FETCH.req && EXTERNAL_MODE
        && !FETCH_DONE && PROGRAM_STORE_STROBE_N
        |=> addr_out_s ##1 strobe_s ##1 FETCH_DONE) else $error("ext fetch");
    // ===
    // Stack reset and program space
    sp_reset_a: assert property (disable iff (1'b0) SRST |=>
        STACK_POINTER == memdec_pkg::SP_RESET) else $error("stack reset");
    vector_addr_a: assert property (VECTOR_REQ && !BOOT_FROM_LOADER
        && !EXTERNAL_MODE |=> FLASH_READ && FLASH_ADDR == 17'h00003
        + {$past(VECTOR_NUM), 3'h0}) else $error("vector");
    fetch_internal_a: assert property (FETCH.req && !FETCH.from_external
        && !BOOT_FROM_LOADER && !EXTERNAL_MODE |=> FLASH_READ && FLASH_ADDR
        == {1'b0, $past(FETCH.addr)} ##1 FETCH_DONE) else $error("fetch");
    code_lock_a: assert property (FETCH.req && FETCH.code_read
        && FETCH.from_external && !CONFIG_BYTE_ZERO[2] && !BOOT_FROM_LOADER
        && !EXTERNAL_MODE |=> CODE_READ_BLOCKED && FETCH_DONE && !FLASH_READ)
        else $error("code lock");
    // ===
    // Data space
    push_order_a: assert property (STACK.push && !STACK.pop && !STACK.load
        |=> RAM_WE && RAM_ADDR == $past(STACK_POINTER) + 8'h01
        && STACK_POINTER == $past(STACK_POINTER) + 8'h01) else $error("push");
    pop_order_a: assert property (STACK.pop && !STACK.push && !STACK.load
        |=> RAM_ADDR == $past(STACK_POINTER) && !RAM_WE
        && STACK_POINTER == $past(STACK_POINTER) - 8'h01) else $error("pop");
    sfr_decode_a: assert property (DATA.req && !REG_REQ && !BIT_REQ
        && !STACK.push && !STACK.pop |=> SFR_SEL == ($past(DATA.direct)
        && $past(DATA.addr[7])) && SFR_BIT_OK == (SFR_SEL
        && $past(DATA.addr[2:0]) == 3'h0)) else $error("decode");
    xmove_route_a: assert property (XMOVE_REQ && XMOVE_WIDE
        |=> $past(AUX_RAM_ENABLE && XMOVE_ADDR <= 16'h03ff)
        ? (DATA_RD_N && DATA_WR_N) : (DATA_RD_N == $past(XMOVE_WRITE)
        && DATA_WR_N != $past(XMOVE_WRITE))) else $error("xmove strobes");
endmodule : mem_space_decoder_assertions

// ---- verif/mem_space_decoder_tb.sv ----
`timescale 1ns/1ps
module mem_space_decoder_tb;
    logic CLK = 0, SRST, POWER_ON, EXTERNAL_ACCESS_SELECT, BOOT_FROM_LOADER;
    logic AUX_RAM_ENABLE, VECTOR_REQ, REG_REQ, BIT_REQ, CALL_REQ, XMOVE_REQ;
    logic XMOVE_WRITE, XMOVE_WIDE, FLASH_READ, FETCH_DONE, CODE_READ_BLOCKED;
    logic PORT0_OE, PROGRAM_STORE_STROBE_N, DATA_RD_N, DATA_WR_N, SFR_SEL;
    logic SFR_BIT_OK, RAM_WE, BIT_VALUE, EXTERNAL_MODE;
    logic [7:0] CONFIG_BYTE_ZERO, PROGRAM_STATUS_WORD, BIT_ADDR, XMOVE_WDATA;
    logic [7:0] PORT0_IN, PORT0_GPIO, PORT2_GPIO, FETCH_DATA, PORT0_OUT;
    logic [7:0] PORT2_OUT, RAM_ADDR, RAM_WDATA, RAM_RDATA, XMOVE_RDATA;
    logic [7:0] STACK_POINTER;
    logic [15:0] RETURN_ADDR, XMOVE_ADDR, START_ADDR;
    logic [16:0] FLASH_ADDR;
    logic [3:0] VECTOR_NUM;
    logic [2:0] REG_NUM;
    memdec_pkg::fetch_req_type FETCH;
    memdec_pkg::data_req_type  DATA;
    memdec_pkg::stack_req_type STACK;
    int n_fail = 0, n_checks = 0;
    mem_space_decoder u_mem_space_decoder (.*);
    ext_prog_mem u_ext_prog_mem (.clk(CLK), .oe(PORT0_OE), .lo(PORT0_OUT),
        .hi(PORT2_OUT), .strobe_n(PROGRAM_STORE_STROBE_N), .rdata(PORT0_IN));
    always #50 CLK = ~CLK;
    function automatic logic [7:0] fd(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : fd
    task ck(input string n, input logic [16:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : ck
    task w1;
        @(posedge CLK);
        #1;
    endtask : w1
    // ===
    // One request, taken at the next edge
    task rq(input int k, input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK);
        case (k)
            0, 1, 2, 3: DATA <= '{1'b1, k[0], !k[1], a[7:0], d};
            4: begin REG_REQ <= 1'b1; REG_NUM <= a[2:0]; end
            5: begin BIT_REQ <= 1'b1; BIT_ADDR <= a[7:0]; end
            6: STACK <= '{1'b1, 1'b0, 1'b0, 8'h00, d};
            7: STACK <= '{1'b0, 1'b1, 1'b0, 8'h00, 8'h00};
            8: STACK <= '{1'b0, 1'b0, 1'b1, d, 8'h00};
            9, 10: begin
                XMOVE_REQ <= 1'b1; XMOVE_WRITE <= k[0] == 1'b0;
                XMOVE_ADDR <= a; XMOVE_WDATA <= d;
            end
            11: begin CALL_REQ <= 1'b1; RETURN_ADDR <= a; end
            12: begin VECTOR_REQ <= 1'b1; VECTOR_NUM <= a[3:0]; end
            default: FETCH <= '{1'b1, a, d[0], d[1]};
        endcase
        @(posedge CLK);
        {DATA.req, REG_REQ, BIT_REQ, STACK.push, STACK.pop, STACK.load,
         XMOVE_REQ, CALL_REQ, VECTOR_REQ, FETCH.req} <= '0;
        #1;
    endtask : rq
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial begin
        #100000;
        n_fail++;
        close_out();
    end
    initial begin
        {DATA, STACK, FETCH, VECTOR_NUM, REG_NUM, BIT_ADDR, RETURN_ADDR} <= '0;
        {VECTOR_REQ, REG_REQ, BIT_REQ, CALL_REQ, XMOVE_REQ, XMOVE_WRITE} <= '0;
        {XMOVE_ADDR, XMOVE_WDATA, PROGRAM_STATUS_WORD, BOOT_FROM_LOADER} <= '0;
        {PORT0_GPIO, PORT2_GPIO, CONFIG_BYTE_ZERO} <= 24'h0000ff;
        {SRST, POWER_ON, EXTERNAL_ACCESS_SELECT, XMOVE_WIDE} <= 4'hf;
        AUX_RAM_ENABLE <= 1'b1;
        repeat (4) @(posedge CLK);
        {SRST, POWER_ON} <= 2'b00;
        @(posedge CLK) EXTERNAL_ACCESS_SELECT <= 1'b0;
        repeat (4) w1;
        ck("start", 17'h0, START_ADDR);
        ck("sp", 17'h07, STACK_POINTER);
        ck("ext", 17'h0, EXTERNAL_MODE);
        rq(13, 16'h1234, 8'h00); ck("fa", 17'h01234, FLASH_ADDR);
        for (int n = 0; n < 4; n++) begin
            rq(12, n, 8'h00); ck("vec", 17'h3 + 8 * n, FLASH_ADDR);
        end
        @(posedge CLK) CONFIG_BYTE_ZERO <= 8'hfb;
        rq(13, 16'h0100, 8'h03); ck("blk", 17'h1, CODE_READ_BLOCKED);
        ck("bdat", 17'hff, FETCH_DATA);
        @(posedge CLK) CONFIG_BYTE_ZERO <= 8'hff;
        rq(13, 16'h0100, 8'h03); ck("unb", 17'h0, CODE_READ_BLOCKED);
        @(posedge CLK) BOOT_FROM_LOADER <= 1'b1;
        rq(12, 1, 8'h00); ck("lvec", 17'h1000b, FLASH_ADDR);
        rq(13, 16'h0000, 8'h00); ck("lst", 17'h10000, FLASH_ADDR);
        rq(13, 16'h1000, 8'h00); ck("loe", 17'h1, PORT0_OE);
        w1;
        w1; ck("ldat", fd(16'h1000), FETCH_DATA);
        @(posedge CLK) BOOT_FROM_LOADER <= 1'b0;
        rq(1, 8'h40, 8'h5a);
        rq(2, 8'h40, 8'h00); ck("low", 17'h5a, RAM_RDATA);
        rq(0, 8'h90, 8'h00); ck("s90", 17'h3, {SFR_SEL, SFR_BIT_OK});
        rq(0, 8'h91, 8'h00); ck("s91", 17'h2, {SFR_SEL, SFR_BIT_OK});
        rq(2, 8'h90, 8'h00); ck("ind", 17'h0, SFR_SEL);
        @(posedge CLK) PROGRAM_STATUS_WORD <= 8'h10;
        rq(4, 16'h5, 8'h00); ck("bank", 17'h15, RAM_ADDR);
        rq(1, 8'h21, 8'h08);
        rq(5, 8'h0b, 8'h00); ck("bit", 17'h121, {BIT_VALUE, RAM_ADDR});
        rq(6, 0, 8'h33); ck("push", 17'h808, {RAM_ADDR, STACK_POINTER});
        rq(7, 0, 8'h00); ck("pop", 17'h3307, {RAM_RDATA, STACK_POINTER});
        rq(8, 0, 8'hf0);
        rq(6, 0, 8'h66);
        rq(2, 8'hf1, 8'h00); ck("hi", 17'h66, RAM_RDATA);
        rq(11, 16'habcd, 8'h00);
        w1;
        w1; ck("csp", 17'hf3, STACK_POINTER);
        rq(2, 8'hf2, 8'h00); ck("crl", 17'hcd, RAM_RDATA);
        rq(2, 8'hf3, 8'h00); ck("crh", 17'hab, RAM_RDATA);
        rq(10, 16'h0100, 8'h77);
        rq(9, 16'h0100, 8'h00); ck("aux", 17'h177, {DATA_RD_N, XMOVE_RDATA});
        @(posedge CLK) AUX_RAM_ENABLE <= 1'b0;
        rq(9, 16'h0100, 8'h00); ck("xrd", 17'h0, DATA_RD_N);
        @(posedge CLK) AUX_RAM_ENABLE <= 1'b1;
        rq(10, 16'h8000, 8'h11); ck("xwr", 17'h0, DATA_WR_N);
        @(posedge CLK) {SRST, POWER_ON} <= 2'b11;
        repeat (4) @(posedge CLK);
        {SRST, POWER_ON} <= 2'b00;
        w1; ck("emode", 17'h1, EXTERNAL_MODE);
        rq(13, 16'h2345, 8'h00); ck("eadr", 17'h2345, {PORT2_OUT, PORT0_OUT});
        w1; ck("pss", 17'h0, PROGRAM_STORE_STROBE_N);
        w1; ck("edat", fd(16'h2345), FETCH_DATA);
        close_out();
    end
endmodule : mem_space_decoder_tb
bind mem_space_decoder mem_space_decoder_assertions u_checker (.*);
